// File: rtl/adc_control_clock_select.sv
/*
  Converter control: APB register slave, channel routing, reference
  clock choice, sample timing and result capture.
  Assumes an external converter core that answers each convert request
  with a one-cycle done strobe and a 10-bit value.
*/
// Design decisions made here: the APB interface to the registers and the address map.
// What this block does
// R1 - software picks 10-bit or 8-bit result width
// R2 - channel field also routes two port_b lines and bandgap
// R3 - selecting a channel never takes over the pin's digital function
// R4 - reference clock is bus clock x4 or local async source
// R5 - with async_clock_enable set, conversions continue through stop mode
// R6 - 10-bit results keep the top two bits in the high register
// R7 - long_sample_select lengthens sampling to save power
`timescale 1ns/1ps
module adc_control_clock_select
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    rstn,
  // register bus
  input  wire apb_req_type             apb_req,
  output apb_resp_type                 apb_resp,
  // processor state
  input  wire logic                    cpu_stop,
  // converter core
  output core_ctrl_type                core_ctrl,
  input  wire logic                    core_done,
  input  wire logic [RESULT_WIDTH-1:0] core_data,
  // pin routing
  output logic      [1:0]              port_b_analog_select
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]     status_control;
    logic [7:0]     clock_config;
    logic           complete;
    conv_state_type phase;
    logic [7:0]     sample_count;
    logic [31:0]    prdata;
    logic           pslverr;
  } ctrl_type;

  ctrl_type   state;
  ctrl_type   next_state;
  logic [7:0] result_high;
  logic [7:0] result_low;

  // register decode for pslverr, which setup sets for reads and writes alike
  function automatic logic addr_mapped(input logic [7:0] addr);
    if (addr == STATUS_CONTROL_OFFSET) begin
      return 1'b1;
    end else if (addr == RESULT_HIGH_OFFSET) begin
      return 1'b1;
    end else if (addr == RESULT_LOW_OFFSET) begin
      return 1'b1;
    end else if (addr == CLOCK_CONFIG_OFFSET) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction : addr_mapped

  logic       setup;
  logic       access_write;
  logic       frozen;
  logic [4:0] channel;
  logic       long_sample;
  logic       async_enable;

  assign setup        = apb_req.psel && !apb_req.penable;
  assign access_write = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign channel      = state.status_control[CHANNEL_LSB +: CHANNEL_WIDTH];
  assign long_sample  = state.clock_config[LONG_SAMPLE_BIT];
  assign async_enable = state.clock_config[ASYNC_ENABLE_BIT];
  // without the async source there is no clock in stop, so the sequence
  // simply holds where it is and resumes on wake
  assign frozen       = cpu_stop && !async_enable;                  // R5

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;

    // read data is captured in the setup cycle so pready can stay high
    if (setup) begin
      next_state.pslverr = !addr_mapped(apb_req.paddr);
      next_state.prdata  = 32'h0000_0000;
      if (apb_req.paddr == STATUS_CONTROL_OFFSET) begin
        next_state.prdata[7:0] = state.status_control;
        next_state.prdata[COMPLETE_BIT] = state.complete;
      end else if (apb_req.paddr == RESULT_HIGH_OFFSET) begin
        next_state.prdata[7:0] = result_high;                       // R6
      end else if (apb_req.paddr == RESULT_LOW_OFFSET) begin
        next_state.prdata[7:0] = result_low;
      end else if (apb_req.paddr == CLOCK_CONFIG_OFFSET) begin
        next_state.prdata[7:0] = state.clock_config;
      end
    end

    // conversion sequence
    if (!frozen) begin
      case (state.phase)
        IDLE: begin
          next_state.sample_count = 8'h00;
        end
        SAMPLING: begin
          next_state.sample_count = state.sample_count + 8'h01;
          // longer track time for low power, at the cost of throughput
          if (long_sample) begin                                    // R7
            if (state.sample_count == 8'(LONG_SAMPLE_CYCLES - 1)) begin
              next_state.phase = CONVERTING;
            end
          end else if (state.sample_count == 8'(SHORT_SAMPLE_CYCLES - 1)) begin
            next_state.phase = CONVERTING;
          end
        end
        CONVERTING: begin
          if (core_done) begin
            next_state.complete     = 1'b1;
            next_state.sample_count = 8'h00;
            if (state.status_control[CONTINUOUS_BIT]) begin
              next_state.phase = SAMPLING;
            end else begin
              next_state.phase = IDLE;
            end
          end
        end
        default: begin
          next_state.phase = IDLE;
        end
      endcase
    end

    // register writes; a write to status_control restarts a conversion unless its channel field is CHANNEL_OFF, which returns to IDLE
    if (access_write) begin
      if (apb_req.paddr == STATUS_CONTROL_OFFSET) begin
        next_state.status_control = {2'b00, apb_req.pwdata[5:0]};
        // a done in this same cycle still leaves complete set
        if (!(state.phase == CONVERTING && core_done && !frozen)) begin
          next_state.complete = 1'b0;
        end
        next_state.sample_count = 8'h00;
        if (apb_req.pwdata[4:0] == CHANNEL_OFF) begin
          next_state.phase = IDLE;
        end else begin
          next_state.phase = SAMPLING;                              // R2
        end
      end else if (apb_req.paddr == CLOCK_CONFIG_OFFSET) begin
        next_state.clock_config = {1'b0, apb_req.pwdata[6:5], 1'b0,
                                   apb_req.pwdata[3:0]};             // R1
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state                <= '0;
      state.status_control <= STATUS_RESET;
      state.clock_config   <= CLOCK_RESET;
      state.phase          <= IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // result capture
  // ---------------------------------------------------------------
  adc_result_store u_result_store (
    .clock       (clock),
    .rstn        (rstn),
    .load        (state.phase == CONVERTING && core_done && !frozen),
    .mode_10bit  (state.clock_config[MODE_10BIT_BIT]),              // R1
    .data        (core_data),
    .result_high (result_high),
    .result_low  (result_low)
  );

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign apb_resp.pready  = 1'b1;
  assign apb_resp.pslverr = state.pslverr && apb_req.psel && apb_req.penable;
  assign apb_resp.prdata  = state.prdata;

  // core controls
  assign core_ctrl.sample     = (state.phase == SAMPLING) && !frozen;
  assign core_ctrl.convert    = (state.phase == CONVERTING) && !frozen;
  assign core_ctrl.channel    = channel;                            // R2
  assign core_ctrl.mode_10bit = state.clock_config[MODE_10BIT_BIT];
  // in stop only the local source runs, so it is forced when allowed
  assign core_ctrl.ref_clock_async =
    state.clock_config[CLOCK_SOURCE_BIT] || (cpu_stop && async_enable); // R4
  assign core_ctrl.run_in_stop = async_enable;                      // R5
  assign core_ctrl.divider    = state.clock_config[DIVIDER_LSB +: DIVIDER_WIDTH];

  // analog switch only; the port's digital path and direction stay with
  // the port logic, so software must make the pin an input itself
  assign port_b_analog_select[0] = (channel == CHANNEL_PORT_B_LINE0); // R3
  assign port_b_analog_select[1] = (channel == CHANNEL_PORT_B_LINE1); // R3

endmodule : adc_control_clock_select

// File: include/adc_ctrl_pkg.sv
/*
  Shared constants and carrier types for the converter control block:
  register offsets, field positions, reset values, sample timing and the
  APB and converter-core carrier structs.
  Assumes a 100 MHz register clock and a 32-bit APB master.
*/
package adc_ctrl_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] STATUS_CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] RESULT_HIGH_OFFSET    = 8'h04;
  localparam logic [7:0] RESULT_LOW_OFFSET     = 8'h08;
  localparam logic [7:0] CLOCK_CONFIG_OFFSET   = 8'h0C;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CHANNEL_LSB      = 0;    // status_control [4:0]
  localparam int CHANNEL_WIDTH    = 5;
  localparam int CONTINUOUS_BIT   = 5;    // status_control
  localparam int COMPLETE_BIT     = 7;    // status_control, read only
  localparam int CLOCK_SOURCE_BIT = 0;    // clock_config: 1 = async source
  localparam int MODE_10BIT_BIT   = 1;    // clock_config: 1 = 10-bit results
  localparam int LONG_SAMPLE_BIT  = 2;    // clock_config
  localparam int ASYNC_ENABLE_BIT = 3;    // clock_config
  localparam int DIVIDER_LSB      = 5;    // clock_config [6:5]
  localparam int DIVIDER_WIDTH    = 2;
  localparam int RESULT_WIDTH     = 10;
  localparam int HIGH_BITS        = 2;

  // ---------------------------------------------------------------
  // channel codes and reset values
  // ---------------------------------------------------------------
  localparam logic [4:0] CHANNEL_PORT_B_LINE0 = 5'h08;
  localparam logic [4:0] CHANNEL_PORT_B_LINE1 = 5'h09;
  localparam logic [4:0] CHANNEL_BANDGAP      = 5'h1A;
  localparam logic [4:0] CHANNEL_OFF          = 5'h1F;
  localparam logic [7:0] STATUS_RESET         = 8'h1F;
  localparam logic [7:0] CLOCK_RESET          = 8'h00;

  // ---------------------------------------------------------------
  // sample timing
  // ---------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS   = 10;
  localparam int SHORT_SAMPLE_NS   = 40;
  localparam int LONG_SAMPLE_NS    = 200;
  localparam int SHORT_SAMPLE_CYCLES =
    (SHORT_SAMPLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int LONG_SAMPLE_CYCLES =
    (LONG_SAMPLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_resp_type;

  typedef struct packed {
    logic       sample;          // track phase on the selected input
    logic       convert;         // successive approximation, held until done
    logic [4:0] channel;
    logic       mode_10bit;
    logic       ref_clock_async; // 0 = bus clock x4, 1 = local async source
    logic       run_in_stop;
    logic [1:0] divider;
  } core_ctrl_type;

  typedef enum logic [1:0] {IDLE, SAMPLING, CONVERTING} conv_state_type;

endpackage : adc_ctrl_pkg

// File: rtl/adc_result_store.sv
/*
  Result holder: splits a finished conversion into the high and low
  result bytes according to the result-width mode.
  Assumes the core delivers a 10-bit value with a one-cycle load strobe.
*/
`timescale 1ns/1ps
module adc_result_store
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    rstn,
  // finished conversion
  input  wire logic                    load,
  input  wire logic                    mode_10bit,
  input  wire logic [RESULT_WIDTH-1:0] data,
  // stored result bytes
  output logic      [7:0]              result_high,
  output logic      [7:0]              result_low
);

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } store_type;

  store_type state;
  store_type next_state;

  // the mode is sampled with the data so a later mode change cannot
  // reinterpret a stored result
  always_comb begin
    next_state = state;
    if (load) begin
      if (mode_10bit) begin
        next_state.high = {6'h00, data[RESULT_WIDTH-1 -: HIGH_BITS]}; // R6
        next_state.low  = data[7:0];                                 // R6
      end else begin
        next_state.high = 8'h00;
        next_state.low  = data[RESULT_WIDTH-1 -: 8];                 // R1
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign result_high = state.high;
  assign result_low  = state.low;

endmodule : adc_result_store

// File: sim/adc_control_clock_select_props.sv
/*
  Port checker for the converter control block.
  Assumes it is bound to adc_control_clock_select with one clock domain.
*/
`timescale 1ns/1ps
module adc_control_clock_select_props
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input wire logic                    clock,
  input wire logic                    rstn,
  // watched ports
  input wire apb_req_type             apb_req,
  input wire apb_resp_type            apb_resp,
  input wire logic                    cpu_stop,
  input wire core_ctrl_type           core_ctrl,
  input wire logic                    core_done,
  input wire logic [RESULT_WIDTH-1:0] core_data,
  input wire logic [1:0]              port_b_analog_select
);
  // ---------------------------------------------------------------
  // port relations
  // ---------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  pb_route_a: assert property (port_b_analog_select ==
    {core_ctrl.channel == CHANNEL_PORT_B_LINE1, core_ctrl.channel == CHANNEL_PORT_B_LINE0})
    else $error("port b routing wrong");
  ref_async_a: assert property (
    cpu_stop && core_ctrl.run_in_stop |-> core_ctrl.ref_clock_async)
    else $error("reference not async in stop");
  stop_freeze_a: assert property (
    cpu_stop && !core_ctrl.run_in_stop |-> !core_ctrl.sample && !core_ctrl.convert)
    else $error("converter runs in stop");
  done_ends_a: assert property (
    core_done && core_ctrl.convert && (!cpu_stop || core_ctrl.run_in_stop)
    |=> !core_ctrl.convert)
    else $error("convert held after done");
  sample_min_a: assert property (
    $rose(core_ctrl.sample) |-> (core_ctrl.sample || cpu_stop)[*4])
    else $error("sample phase too short");
  sample_max_a: assert property (
    $rose(core_ctrl.sample) && !cpu_stop |-> ##[4:20] !core_ctrl.sample)
    else $error("sample phase too long");
  conv_next_a: assert property (
    $fell(core_ctrl.sample) && !cpu_stop && !$past(apb_req.penable)
    |-> core_ctrl.convert)
    else $error("no convert after sample");
  err_phase_a: assert property (
    apb_resp.pslverr |-> apb_req.psel && apb_req.penable)
    else $error("error outside access phase");
  ready_now_a: assert property (
    apb_req.psel && apb_req.penable |-> apb_resp.pready)
    else $error("access phase not ready");
endmodule : adc_control_clock_select_props

bind adc_control_clock_select adc_control_clock_select_props u_props (
  .clock(clock), .rstn(rstn), .apb_req(apb_req), .apb_resp(apb_resp),
  .cpu_stop(cpu_stop), .core_ctrl(core_ctrl), .core_done(core_done),
  .core_data(core_data), .port_b_analog_select(port_b_analog_select));

// File: sim/adc_core_model.sv
/*
  Behavioural converter core: answers convert with a one-cycle done.
  Assumes latency and value are set by the bench before a conversion.
*/
`timescale 1ns/1ps
module adc_core_model
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    rstn,
  // control side
  input  wire core_ctrl_type           core_ctrl,
  input  wire logic [7:0]              latency,
  input  wire logic [RESULT_WIDTH-1:0] value,
  // answer
  output logic                         core_done,
  output logic      [RESULT_WIDTH-1:0] core_data
);
  // ---------------------------------------------------------------
  // conversion timer
  // ---------------------------------------------------------------
  logic [7:0] count;

  // data is scrambled outside done so a stale value never looks valid
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count     <= 8'h00;
      core_done <= 1'b0;
      core_data <= '0;
    end else begin
      core_done <= 1'b0;
      core_data <= ~core_data;
      if (core_ctrl.convert && !core_done) begin
        if (count == latency) begin
          core_done <= 1'b1;
          core_data <= value;
          count     <= 8'h00;
        end else begin
          count <= count + 8'h01;
        end
      end else begin
        count <= 8'h00;
      end
    end
  end
endmodule : adc_core_model

// File: sim/adc_control_clock_select_test.sv
/*
  Self-checking bench for the converter control block.
  Assumes the core model in adc_core_model and a bound port checker.
*/
`timescale 1ns/1ps
module adc_control_clock_select_test
  import adc_ctrl_pkg::*;
;
  // ---------------------------------------------------------------
  // signals and instances
  // ---------------------------------------------------------------
  logic                    clock, rstn, cpu_stop, core_done, err;
  apb_req_type             apb_req;
  apb_resp_type            apb_resp;
  core_ctrl_type           core_ctrl;
  logic [RESULT_WIDTH-1:0] core_data, conv_value;
  logic [1:0]              port_b_analog_select;
  logic [7:0]              latency;
  logic [31:0]             rd;
  int                      bad_count, n_checks, samples;

  adc_control_clock_select u_dut (.clock(clock), .rstn(rstn), .apb_req(apb_req),
    .apb_resp(apb_resp), .cpu_stop(cpu_stop), .core_ctrl(core_ctrl),
    .core_done(core_done), .core_data(core_data),
    .port_b_analog_select(port_b_analog_select));
  adc_core_model u_core (.clock(clock), .rstn(rstn), .core_ctrl(core_ctrl),
    .latency(latency), .value(conv_value), .core_done(core_done), .core_data(core_data));

  // counted on the falling edge so design updates have settled
  always @(negedge clock) samples += (core_ctrl.sample === 1'b1);

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one full transfer; an edge passes after release before the next setup
  // a slave that never answers is cut by the watchdog, not here
  task apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: data};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (apb_resp.pready !== 1'b1);
    rd = apb_resp.prdata;
    err = apb_resp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  // a done that never comes is cut by the watchdog
  task wait_done;
    while (core_done !== 1'b1) begin
      @(negedge clock);
    end
    @(posedge clock);
  endtask : wait_done

  // one conversion with expected byte split worked out from the mode
  task conv(input logic [4:0] ch, input logic [7:0] cfg, input logic [9:0] v);
    conv_value <= v;
    apb(1'b1, CLOCK_CONFIG_OFFSET, {24'h0, cfg});
    samples = 0;
    apb(1'b1, STATUS_CONTROL_OFFSET, {27'h0, ch});
    wait_done();
    check(samples, cfg[LONG_SAMPLE_BIT] ? LONG_SAMPLE_CYCLES : SHORT_SAMPLE_CYCLES);
    check({30'h0, port_b_analog_select},
          {30'h0, ch == CHANNEL_PORT_B_LINE1, ch == CHANNEL_PORT_B_LINE0});
    check({27'h0, core_ctrl.channel}, {27'h0, ch});
    apb(1'b0, STATUS_CONTROL_OFFSET, 32'h0);
    check(rd, {24'h0, 3'h4, ch});
    apb(1'b0, RESULT_HIGH_OFFSET, 32'h0);
    check(rd, cfg[1] ? {30'h0, v[9:8]} : 32'h0);
    apb(1'b0, RESULT_LOW_OFFSET, 32'h0);
    check(rd, cfg[1] ? {24'h0, v[7:0]} : {24'h0, v[9:2]});
  endtask : conv

  task t_regs;
    apb(1'b0, STATUS_CONTROL_OFFSET, 32'h0);
    check(rd, {24'h0, STATUS_RESET});
    apb(1'b0, CLOCK_CONFIG_OFFSET, 32'h0);
    check(rd, {24'h0, CLOCK_RESET});
    apb(1'b1, CLOCK_CONFIG_OFFSET, 32'hFFFF_FFFF);
    check({31'h0, core_ctrl.ref_clock_async}, 32'h1);
    check({28'h0, core_ctrl.divider, core_ctrl.mode_10bit, core_ctrl.run_in_stop},
          32'hF);
    apb(1'b0, CLOCK_CONFIG_OFFSET, 32'h0);
    check(rd, 32'h6F);
    apb(1'b1, CLOCK_CONFIG_OFFSET, 32'h0);
    check({31'h0, core_ctrl.ref_clock_async}, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    check({rd[30:0], err}, 32'h1);
  endtask : t_regs

  task t_modes;
    latency <= 8'h00;
    conv(CHANNEL_PORT_B_LINE0, 8'h02, 10'h2A5);
    latency <= 8'h0C;
    conv(CHANNEL_PORT_B_LINE1, 8'h00, 10'h2A5);
    conv(CHANNEL_BANDGAP, 8'h06, 10'h155);
  endtask : t_modes

  // frozen without async enable, running through stop with it
  task t_stop;
    cpu_stop <= 1'b1;
    conv(5'h02, 8'h0A, 10'h3C3);
    check({31'h0, core_ctrl.ref_clock_async}, 32'h1);
    apb(1'b1, CLOCK_CONFIG_OFFSET, 32'h02);
    samples = 0;
    apb(1'b1, STATUS_CONTROL_OFFSET, 32'h03);
    repeat (30) @(posedge clock);
    apb(1'b0, STATUS_CONTROL_OFFSET, 32'h0);
    check(rd, 32'h03);
    check(samples, 32'h0);
    cpu_stop <= 1'b0;
    wait_done();
    apb(1'b0, STATUS_CONTROL_OFFSET, 32'h0);
    check(rd, 32'h83);
  endtask : t_stop

  // continuous mode resamples after each result; channel off, written
  // while converting, stops the sequence
  task t_cont;
    apb(1'b1, STATUS_CONTROL_OFFSET, 32'h22);
    wait_done();
    @(negedge clock);
    check({31'h0, core_ctrl.sample}, 32'h1);
    repeat (6) @(posedge clock);
    check({31'h0, core_ctrl.convert}, 32'h1);
    apb(1'b1, STATUS_CONTROL_OFFSET, {27'h0, CHANNEL_OFF});
    check({30'h0, core_ctrl.sample, core_ctrl.convert}, 32'h0);
  endtask : t_cont

  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // ---------------------------------------------------------------
  // clock, sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    rstn = 1'b0;
    cpu_stop = 1'b0;
    apb_req = '0;
    latency = 8'h03;
    conv_value = '0;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    t_regs();
    t_modes();
    t_stop();
    t_cont();
    report_and_stop();
  end

  // conversions are short, so a generous fixed span cuts a hang
  initial begin
    #50us;
    bad_count++;
    report_and_stop();
  end
endmodule : adc_control_clock_select_test
